/* File: src/ors_pkg.sv */
// Package of the output ramp sequencer: register map, reset values, timing and state types.
// Assumes one 125 MHz master reference clock shared by every converter in the system.
package ors_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_SLEW_RAMP_CONFIG  = 8'h03;
  localparam logic [7:0] ADDR_POWER_UP_DELAY    = 8'h05;
  localparam logic [7:0] ADDR_POWER_DOWN_DELAY  = 8'h06;

  // Field layout of slew_ramp_config, bit 7 down to bit 0.
  typedef struct packed {
    logic       unused;
    logic [2:0] riseCode;
    logic       rampControlEnable;
    logic [2:0] fallCode;
  } ors_slew_s;

  localparam logic [7:0] UP_DELAY_RST      = 8'h00;
  localparam logic [5:0] DOWN_DELAY_RST    = 6'h0B;
  localparam logic [2:0] RISE_RST          = 3'h1;
  localparam logic [2:0] RISE_TERM_RST     = 3'h0;
  localparam logic [2:0] FALL_RST          = 3'h4;
  localparam logic [2:0] FALL_TERM_RST     = 3'h3;
  localparam logic       RAMP_EN_RST       = 1'b1;
  localparam ors_slew_s  SLEW_RST          = '{1'b0, RISE_RST, RAMP_EN_RST, FALL_RST};

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned STEP_TIME_NS  = 5000;
  localparam int unsigned MS_NS         = 1000000;
  localparam int unsigned TICK_CYC      = STEP_TIME_NS / CLK_PERIOD_NS;
  localparam logic [7:0]  TICKS_PER_MS  = 8'(MS_NS / STEP_TIME_NS);
  localparam logic [1:0]  STRAP_WAIT    = 2'h2;

  // Ticks of 5 us per 10 mV step for each slew code (same magnitude up and down).
  localparam logic [5:0] FACT_0P05 = 6'h28;
  localparam logic [5:0] FACT_0P1  = 6'h14;
  localparam logic [5:0] FACT_0P2  = 6'h0A;
  localparam logic [5:0] FACT_0P25 = 6'h08;
  localparam logic [5:0] FACT_0P5  = 6'h04;
  localparam logic [5:0] FACT_1P0  = 6'h02;
  localparam logic [5:0] FACT_2P0  = 6'h01;

  typedef enum logic [2:0] {
    ST_OFF, ST_ON_DLY, ST_RAMP_UP, ST_ON, ST_OFF_DLY, ST_RAMP_DN
  } ors_phase_e;

  typedef struct packed {
    logic        cmdMeta;
    logic        cmdSync;
    logic        termMeta;
    logic        termSync;
    logic [1:0]  strapCnt;
    ors_slew_s   slewCfg;
    logic [7:0]  upDly;
    logic [5:0]  dnDly;
    ors_phase_e  phase;
    logic [9:0]  tickCnt;
    logic [5:0]  stepCnt;
    logic [15:0] elapsed;
    logic [9:0]  level;
    logic        stageEn;
    logic [7:0]  rdData;
  } ors_state_s;

endpackage : ors_pkg

/* File: src/ors_rate_lut.sv */
// Slew code to step-duration lookup, registered output.
// Assumes the caller holds the code steady; the answer lags the code by one clock.
`timescale 1ns/1ps
module ors_rate_lut
  import ors_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire logic       ce,
  input  wire logic [2:0] code,
  output logic      [5:0] stepFactor
);

  typedef struct packed {
    logic [5:0] factor;
  } ors_lut_s;

  ors_lut_s s_reg;
  ors_lut_s s_next;

  // ----------------------------------------------------------------
  // Lookup
  // ----------------------------------------------------------------
  // Reserved code 7 falls back to the slowest rate, which keeps charging current lowest. [R15]
  always_comb begin
    s_next = s_reg;
    case (code)
      3'h0:    s_next.factor = FACT_0P05; // [R10] [R11]
      3'h1:    s_next.factor = FACT_0P1;
      3'h2:    s_next.factor = FACT_0P2;
      3'h3:    s_next.factor = FACT_0P25;
      3'h4:    s_next.factor = FACT_0P5;
      3'h5:    s_next.factor = FACT_1P0;
      3'h6:    s_next.factor = FACT_2P0;
      default: s_next.factor = FACT_0P05;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg <= '{FACT_0P1};
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign stepFactor = s_reg.factor;

  AST_LUT_HALF_VOLT: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R10]
    (ce && code == 3'h4) |=> (stepFactor == FACT_0P5))
    else $error("Code 4 did not select 0.5 V/ms step time.");

endmodule : ors_rate_lut

/* File: src/ors_ramp_sequencer.sv */
// Output ramp sequencer: turn-on/turn-off delays and slewed reference stepping.
// Assumes register writes come from the programming path on ref_clk; runCmd and
// busTerminator are pins and are synchronised here.
//
// Notes on behaviour
// [R1] After turn-on, wait the programmed turn-on delay before ramping up.
// [R2] Power-up delay register: 8-bit milliseconds, all read-write, resets to zero.
// [R3] With falling slew, turn-off delay ends when the output reaches zero.
// [R4] Without falling slew, turn-off delay only times switch-off of both switches.
// [R5] Ramp-down starts after turn-off delay minus output over falling rate.
// [R6] Manager programs turn-off delay so that computed wait stays positive.
// [R7] Power-down delay: 6-bit milliseconds, default 11, upper two bits read zero.
// [R8] Slew is made by fixed 10 mV reference steps; step time sets rate.
// [R9] Step time is divided down from the manager's master clock.
// [R10] Rising code 0..6 maps 0.05 to 2.0 V/ms; default 1, terminator 0.
// [R11] Falling codes map -0.1 to -2.0 V/ms; default 4, terminator 3; here codes 0..6 share the rising table, -0.05 to -2.0 V/ms.
// [R12] One enable bit switches controlled ramping; resets to enabled.
// [R13] Top bit of slew configuration always reads zero.
// [R14] Manager sets delays and slews by writing the three registers.
// [R15] Rising slew and overcurrent threshold must keep charging current below limit.
// [R16] Delay and slew registers accept rewrites at any time.
// [R17] Delays count in millisecond ticks; zero delay ramps immediately.
// [R18] A computed ramp-down wait of zero or less starts ramping at once.
`timescale 1ns/1ps
module ors_ramp_sequencer
  import ors_pkg::*;
#(
  parameter int unsigned STEP_TICK_CYCLES = TICK_CYC
)(
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire logic       ce,
  input  wire logic       runCmd,
  input  wire logic       busTerminator,
  input  wire logic [9:0] targetSteps,
  input  wire logic       regWrEn,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  output logic      [7:0] regRdData,
  output logic      [9:0] vrefSteps,
  output logic            powerStageEn,
  output logic            rampActive
);

  localparam logic [9:0] TICK_LAST = 10'(STEP_TICK_CYCLES - 1);

  ors_state_s  s_reg;
  ors_state_s  s_next;
  logic [5:0]  riseFactor;
  logic [5:0]  fallFactor;
  logic        tick;
  logic [15:0] limitUp;
  logic [15:0] limitDn;
  logic [16:0] dnReach;

  // ----------------------------------------------------------------
  // Step-time lookups
  // ----------------------------------------------------------------
  ors_rate_lut uRiseLut (
    .ref_clk    (ref_clk),
    .rst_b      (rst_b),
    .ce         (ce),
    .code       (s_reg.slewCfg.riseCode),
    .stepFactor (riseFactor)
  );

  ors_rate_lut uFallLut (
    .ref_clk    (ref_clk),
    .rst_b      (rst_b),
    .ce         (ce),
    .code       (s_reg.slewCfg.fallCode),
    .stepFactor (fallFactor)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  assign tick    = (s_reg.tickCnt == '0); // [R9]
  assign limitUp = 16'(s_reg.upDly) * 16'(TICKS_PER_MS); // [R17]
  assign limitDn = 16'(s_reg.dnDly) * 16'(TICKS_PER_MS);
  // Elapsed wait plus the time the remaining ramp needs; reaching the delay starts the ramp.
  assign dnReach = 17'(s_reg.elapsed) + 17'(16'(s_reg.level) * 16'(fallFactor)); // [R5]

  always_comb begin
    s_next          = s_reg;
    s_next.cmdMeta  = runCmd;
    s_next.cmdSync  = s_reg.cmdMeta;
    s_next.termMeta = busTerminator;
    s_next.termSync = s_reg.termMeta;
    s_next.tickCnt  = tick ? TICK_LAST : s_reg.tickCnt - 10'd1;

    // The strap is taken once the synchroniser holds a settled value after reset.
    if (s_reg.strapCnt != STRAP_WAIT + 2'd1) begin
      s_next.strapCnt = s_reg.strapCnt + 2'd1;
      if (s_reg.strapCnt == STRAP_WAIT && s_reg.termSync) begin
        s_next.slewCfg.riseCode = RISE_TERM_RST; // [R10]
        s_next.slewCfg.fallCode = FALL_TERM_RST; // [R11]
      end
    end

    if (regWrEn) begin // [R16] [R14]
      case (regAddr)
        ADDR_SLEW_RAMP_CONFIG: s_next.slewCfg = {1'b0, regWrData[6:0]}; // [R13] [R12]
        ADDR_POWER_UP_DELAY:   s_next.upDly   = regWrData; // [R2]
        ADDR_POWER_DOWN_DELAY: s_next.dnDly   = regWrData[5:0]; // [R7]
        default:               s_next.upDly   = s_reg.upDly;
      endcase
    end

    case (regAddr)
      ADDR_SLEW_RAMP_CONFIG: s_next.rdData = s_reg.slewCfg;
      ADDR_POWER_UP_DELAY:   s_next.rdData = s_reg.upDly;
      ADDR_POWER_DOWN_DELAY: s_next.rdData = {2'b00, s_reg.dnDly}; // [R7]
      default:               s_next.rdData = 8'h00;
    endcase

    case (s_reg.phase)
      ST_OFF: begin
        s_next.level   = '0;
        s_next.stageEn = 1'b0;
        if (s_reg.cmdSync) begin
          s_next.elapsed = '0;
          s_next.phase   = ST_ON_DLY;
        end
      end
      ST_ON_DLY: begin
        if (!s_reg.cmdSync) begin
          s_next.phase = ST_OFF;
        end else if (s_reg.elapsed >= limitUp) begin // [R1] [R17]
          s_next.stageEn = 1'b1;
          s_next.stepCnt = '0;
          if (s_reg.slewCfg.rampControlEnable) begin
            s_next.phase = ST_RAMP_UP;
          end else begin
            s_next.level = targetSteps;
            s_next.phase = ST_ON;
          end
        end else if (tick) begin
          s_next.elapsed = s_reg.elapsed + 16'd1;
        end
      end
      ST_RAMP_UP: begin
        if (!s_reg.cmdSync) begin
          s_next.elapsed = '0;
          s_next.phase   = ST_OFF_DLY;
        end else if (s_reg.level >= targetSteps) begin
          s_next.level = targetSteps;
          s_next.phase = ST_ON;
        end else if (tick) begin
          if (s_reg.stepCnt + 6'd1 >= riseFactor) begin // [R8]
            s_next.level   = s_reg.level + 10'd1;
            s_next.stepCnt = '0;
          end else begin
            s_next.stepCnt = s_reg.stepCnt + 6'd1;
          end
        end
      end
      ST_ON: begin
        s_next.level = targetSteps;
        if (!s_reg.cmdSync) begin
          s_next.elapsed = '0;
          s_next.phase   = ST_OFF_DLY;
        end
      end
      ST_OFF_DLY: begin
        if (s_reg.cmdSync) begin
          s_next.stepCnt = '0;
          s_next.phase   = ST_RAMP_UP;
        end else if (s_reg.slewCfg.rampControlEnable) begin
          // A wait the manager left too short simply starts the ramp at once.
          if (dnReach >= 17'(limitDn)) begin // [R5] [R18] [R6]
            s_next.stepCnt = '0;
            s_next.phase   = ST_RAMP_DN;
          end else if (tick) begin
            s_next.elapsed = s_reg.elapsed + 16'd1;
          end
        end else if (s_reg.elapsed >= limitDn) begin // [R4]
          s_next.stageEn = 1'b0;
          s_next.level   = '0;
          s_next.phase   = ST_OFF;
        end else if (tick) begin
          s_next.elapsed = s_reg.elapsed + 16'd1;
        end
      end
      ST_RAMP_DN: begin
        if (s_reg.cmdSync) begin
          s_next.stepCnt = '0;
          s_next.phase   = ST_RAMP_UP;
        end else if (s_reg.level == '0) begin // [R3]
          s_next.stageEn = 1'b0;
          s_next.phase   = ST_OFF;
        end else if (tick) begin
          if (s_reg.stepCnt + 6'd1 >= fallFactor) begin // [R8]
            s_next.level   = s_reg.level - 10'd1;
            s_next.stepCnt = '0;
          end else begin
            s_next.stepCnt = s_reg.stepCnt + 6'd1;
          end
        end
      end
      default: s_next.phase = ST_OFF;
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg <= '{1'b0, 1'b0, 1'b0, 1'b0, 2'b00, SLEW_RST, UP_DELAY_RST, // [R12] [R2]
                 DOWN_DELAY_RST, ST_OFF, 10'h000, 6'h00, 16'h0000, // [R7]
                 10'h000, 1'b0, 8'h00};
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign regRdData    = s_reg.rdData;
  assign vrefSteps    = s_reg.level;
  assign powerStageEn = s_reg.stageEn;
  assign rampActive   = (s_reg.phase == ST_RAMP_UP) || (s_reg.phase == ST_RAMP_DN);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  AST_ZERO_DELAY_GO: assert property ( // [R17]
    (ce && s_reg.phase == ST_ON_DLY && s_reg.cmdSync && s_reg.upDly == 8'h00)
    |=> (s_reg.phase != ST_ON_DLY))
    else $error("Zero turn-on delay did not start the ramp.");
  AST_NO_EARLY_RAMP: assert property ( // [R1]
    (s_reg.phase == ST_ON_DLY && s_reg.cmdSync && s_reg.elapsed < limitUp)
    |=> (s_reg.phase == ST_ON_DLY && !powerStageEn))
    else $error("Ramp started before the turn-on delay elapsed.");
  AST_UP_DELAY_WRITE: assert property ( // [R2]
    (ce && regWrEn && regAddr == ADDR_POWER_UP_DELAY) |=> (s_reg.upDly == $past(regWrData)))
    else $error("Power-up delay write was lost.");
  AST_DOWN_TOP_ZERO: assert property ( // [R7]
    (ce && regAddr == ADDR_POWER_DOWN_DELAY) |=> (regRdData[7:6] == 2'b00))
    else $error("Power-down delay upper bits read nonzero.");
  AST_SLEW_TOP_ZERO: assert property ( // [R13]
    (ce && regAddr == ADDR_SLEW_RAMP_CONFIG) |=> (regRdData[7] == 1'b0))
    else $error("Slew configuration bit 7 read nonzero.");
  AST_STEP_ONE: assert property ( // [R8]
    (s_reg.phase == ST_RAMP_DN)
    |=> (vrefSteps == $past(vrefSteps) || vrefSteps == $past(vrefSteps) - 10'd1))
    else $error("Ramp-down moved by more than one step.");
  AST_STEP_ON_TICK: assert property ( // [R9]
    (s_reg.phase == ST_RAMP_UP && s_reg.cmdSync && !tick && s_reg.level < targetSteps)
    |=> (vrefSteps == $past(vrefSteps)))
    else $error("Reference stepped between ticks.");
  AST_NOSLEW_OFF: assert property ( // [R4]
    (ce && s_reg.phase == ST_OFF_DLY && !s_reg.cmdSync && !s_reg.slewCfg.rampControlEnable
     && s_reg.elapsed >= limitDn) |=> (s_reg.phase == ST_OFF && !powerStageEn))
    else $error("Switches not released at end of turn-off delay.");
  AST_DN_START: assert property ( // [R5]
    (ce && s_reg.phase == ST_OFF_DLY && !s_reg.cmdSync && s_reg.slewCfg.rampControlEnable
     && dnReach >= 17'(limitDn)) |=> (s_reg.phase == ST_RAMP_DN))
    else $error("Ramp-down did not start when due.");
  AST_DN_END: assert property ( // [R3]
    (ce && s_reg.phase == ST_RAMP_DN && !s_reg.cmdSync && s_reg.level == '0)
    |=> (!powerStageEn && s_reg.phase == ST_OFF))
    else $error("Stage stayed on after reaching zero.");

  COV_TURN_ON: cover property (s_reg.phase == ST_RAMP_UP ##1 s_reg.phase == ST_ON);
  COV_RAMP_DOWN_DONE: cover property (s_reg.phase == ST_RAMP_DN ##1 s_reg.phase == ST_OFF);
  COV_IMMEDIATE_DN: cover property (s_reg.phase == ST_ON ##1
    (s_reg.phase == ST_OFF_DLY && s_reg.elapsed == '0) ##1 s_reg.phase == ST_RAMP_DN);

endmodule : ors_ramp_sequencer

/* File: verif/ors_mgr_model.sv */
// Behavioural model of the power manager that programs the sequencer's registers and run pin.
// Assumes the parallel register port of the sequencer and a shared 125 MHz master clock.
`timescale 1ns/1ps
module ors_mgr_model
  import ors_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic [7:0] regRdData,
  output logic            regWrEn,
  output logic      [7:0] regAddr,
  output logic      [7:0] regWrData,
  output logic            runCmd
);
  // ----------------------------------------------------------------
  // Idle levels
  // ----------------------------------------------------------------
  initial begin
    regWrEn   = 1'b0;
    regAddr   = 8'h00;
    regWrData = 8'h00;
    runCmd    = 1'b0;
  end

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  // Delays are only ever set through these register writes; slew codes also take the terminator strap after reset.
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge ref_clk);
    #1;
    regWrEn   = 1'b1;
    regAddr   = addr;
    regWrData = data;
    @(posedge ref_clk);
    #1;
    regWrEn   = 1'b0;
    // Released data lines are scrambled so a stale byte can never look valid.
    regWrData = ~data;
  endtask : wr

  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    @(posedge ref_clk);
    #1;
    regAddr = addr;
    @(posedge ref_clk);
    #1;
    data = regRdData;
  endtask : rd

  task automatic run(input logic on);
    @(posedge ref_clk);
    #1;
    runCmd = on;
  endtask : run
endmodule : ors_mgr_model

/* File: verif/tb.sv */
// Self-checking testbench of the output ramp sequencer.
// Assumes the manager model drives the register port and the run pin; step ticks are shortened.
`timescale 1ns/1ps
module tb;
  import ors_pkg::*;
  localparam int unsigned TICK   = 4;
  localparam int unsigned MS_CYC = TICK * 200;

  logic       ref_clk = 1'b0;
  logic       rst_b;
  logic       ce;
  logic       busTerminator;
  logic [9:0] targetSteps;
  logic       regWrEn;
  logic [7:0] regAddr;
  logic [7:0] regWrData;
  logic       runCmd;
  logic [7:0] regRdData;
  logic [9:0] vrefSteps;
  logic       powerStageEn;
  logic       rampActive;
  int         nErrors = 0;
  int         nTests  = 0;
  int         n;
  int         fact[7] = '{40, 20, 10, 8, 4, 2, 1};

  always #4 ref_clk = ~ref_clk;

  ors_ramp_sequencer #(.STEP_TICK_CYCLES(TICK)) dut (
    .ref_clk(ref_clk), .rst_b(rst_b), .ce(ce), .runCmd(runCmd),
    .busTerminator(busTerminator), .targetSteps(targetSteps), .regWrEn(regWrEn),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .vrefSteps(vrefSteps), .powerStageEn(powerStageEn), .rampActive(rampActive));

  ors_mgr_model mgr (
    .ref_clk(ref_clk), .regRdData(regRdData), .regWrEn(regWrEn), .regAddr(regAddr),
    .regWrData(regWrData), .runCmd(runCmd));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp) begin
      nErrors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // Tick phase and pin synchronisers leave a few cycles of honest jitter.
  task automatic in_win(input int v, input int lo, input int hi);
    check({31'h0000_0000, (v >= lo) && (v <= hi)}, 32'h0000_0001);
  endtask : in_win

  task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    mgr.rd(addr, d);
    check({24'h00_0000, d}, {24'h00_0000, exp});
  endtask : rd_chk

  task automatic wait_lvl(input logic [9:0] lvl, input int maxc, output int cnt);
    cnt = 0;
    while (vrefSteps !== lvl && cnt < maxc) begin
      @(posedge ref_clk);
      #1;
      cnt++;
    end
  endtask : wait_lvl

  task automatic wait_stage(input logic v, input int maxc, output int cnt);
    cnt = 0;
    while (powerStageEn !== v && cnt < maxc) begin
      @(posedge ref_clk);
      #1;
      cnt++;
    end
  endtask : wait_stage

  task automatic do_reset(input logic term);
    rst_b         = 1'b0;
    busTerminator = term;
    repeat (8) @(posedge ref_clk);
    #1;
    rst_b = 1'b1;
    repeat (6) @(posedge ref_clk);
    #1;
  endtask : do_reset

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", nTests, nErrors);
    if (nErrors == 0 && nTests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (30000) @(posedge ref_clk);
    nErrors++;
    finish_test();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    rst_b         = 1'b0;
    busTerminator = 1'b0;
    targetSteps   = 10'h000;
    ce            = 1'b1;
    do_reset(1'b0);
    rd_chk(ADDR_SLEW_RAMP_CONFIG, 8'h1C);
    rd_chk(ADDR_POWER_UP_DELAY, 8'h00);
    rd_chk(ADDR_POWER_DOWN_DELAY, 8'h0B);
    rd_chk(8'h04, 8'h00);
    mgr.wr(ADDR_POWER_UP_DELAY, 8'hA5);
    rd_chk(ADDR_POWER_UP_DELAY, 8'hA5);
    // With the clock enable low, a write strobe must leave every register untouched.
    ce = 1'b0;
    mgr.wr(ADDR_POWER_UP_DELAY, 8'h3C);
    ce = 1'b1;
    rd_chk(ADDR_POWER_UP_DELAY, 8'hA5);
    mgr.wr(ADDR_POWER_DOWN_DELAY, 8'hFF);
    rd_chk(ADDR_POWER_DOWN_DELAY, 8'h3F);
    mgr.wr(ADDR_SLEW_RAMP_CONFIG, 8'hFF);
    rd_chk(ADDR_SLEW_RAMP_CONFIG, 8'h7F);
    $display("test registers done");

    // Rise and fall codes 0 to 6, zero delays: step spacing gives the rate exactly.
    mgr.wr(ADDR_POWER_UP_DELAY, 8'h00);
    mgr.wr(ADDR_POWER_DOWN_DELAY, 8'h00);
    targetSteps = 10'h003;
    for (int i = 0; i < 7; i++) begin
      mgr.wr(ADDR_SLEW_RAMP_CONFIG, {1'b0, i[2:0], 1'b1, i[2:0]});
      mgr.run(1'b1);
      wait_stage(1'b1, 12, n);
      in_win(n, 1, 8);
      wait_lvl(10'h001, 400, n);
      check({31'h0000_0000, rampActive}, 32'h0000_0001);
      wait_lvl(10'h003, 400, n);
      check(n, 8 * fact[i]);
      mgr.run(1'b0);
      wait_lvl(10'h002, 400, n);
      wait_lvl(10'h000, 400, n);
      check(n, 8 * fact[i]);
      check({31'h0000_0000, powerStageEn}, 32'h0000_0001);
      wait_stage(1'b0, 4, n);
      check(n, 1);
    end
    $display("test slew codes done");

    // One millisecond turn-on delay, then a fast ramp to ten steps.
    mgr.wr(ADDR_POWER_UP_DELAY, 8'h01);
    mgr.wr(ADDR_SLEW_RAMP_CONFIG, 8'h6E);
    targetSteps = 10'h00A;
    mgr.run(1'b1);
    wait_stage(1'b1, 1000, n);
    in_win(n, MS_CYC - 8, MS_CYC + 12);
    check({22'h00_0000, vrefSteps}, 32'h0000_0000);
    wait_lvl(10'h00A, 200, n);
    @(posedge ref_clk);
    #1;
    check({31'h0000_0000, rampActive}, 32'h0000_0000);

    // Delay rewritten while on; ramp-down must end within a few cycles of the end of the delay.
    mgr.wr(ADDR_POWER_DOWN_DELAY, 8'h01);
    mgr.run(1'b0);
    repeat (700) @(posedge ref_clk);
    #1;
    check({22'h00_0000, vrefSteps}, 32'h0000_000A);
    wait_stage(1'b0, 200, n);
    in_win(n + 700, MS_CYC - 8, MS_CYC + 16);
    $display("test delays with slew done");

    // Slew disabled: level jumps, and the delay only times switch-off.
    mgr.wr(ADDR_SLEW_RAMP_CONFIG, 8'h66);
    mgr.run(1'b1);
    wait_stage(1'b1, 1000, n);
    repeat (2) @(posedge ref_clk);
    #1;
    check({22'h00_0000, vrefSteps}, 32'h0000_000A);
    mgr.run(1'b0);
    wait_stage(1'b0, 1000, n);
    in_win(n, MS_CYC - 8, MS_CYC + 12);
    check({22'h00_0000, vrefSteps}, 32'h0000_0000);
    $display("test delays without slew done");

    // Terminator strap changes only the slew defaults.
    do_reset(1'b1);
    rd_chk(ADDR_SLEW_RAMP_CONFIG, 8'h0B);
    rd_chk(ADDR_POWER_DOWN_DELAY, 8'h0B);
    $display("test terminator defaults done");
    finish_test();
  end
endmodule : tb
